// >>> rtl/dq_reference_calibration_mode.sv
`timescale 1ns/100ps
// What this block does
// - Mode-set to training register with bit 7 set enters calibration; bit 6 is range
// - Range bit 0 picks higher range, 1 picks lower range
// - Level writes keep bit 7 high and entry range; bits 5:0 become level
// - A training write with bit 7 low leaves range and level unchanged
// - After exit the last written range and level remain the operating reference
// - Code maps linearly from 60% or 45%; codes above 50 reserved
module dq_reference_calibration_mode (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 cmd_valid,
  input  wire logic [3:0]                           cmd_code,
  input  wire logic [2:0]                           cmd_mr_addr,
  input  wire logic [7:0]                           cmd_data,
  input  wire logic                                 per_device_addressing,
  input  wire logic                                 pda_dq0_high,
  output logic                                      cal_mode,
  output logic                                      ref_range,
  output logic      [dq_ref_cal_pkg::LEVEL_W-1:0]   ref_level,
  output logic                                      ref_valid,
  output logic                                      cmd_illegal,
  output logic      [dq_ref_cal_pkg::FRAC_W-1:0]    ref_frac,
  output logic                                      ref_reserved
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    dq_ref_cal_pkg::cal_state_t           mode;
    logic                                 range;
    logic [dq_ref_cal_pkg::LEVEL_W-1:0]   level;
    logic                                 valid;
    logic                                 illegal;
  } cal_regs_t;

  cal_regs_t st_r;
  cal_regs_t st_nxt;

  logic      in_cal;
  logic      mode_set_cmd;
  logic      train_wr;
  logic      allowed_cmd;
  logic      cal_bit;
  logic      range_bit;
  logic [dq_ref_cal_pkg::LEVEL_W-1:0] level_field;

  // --------------------------------------------------------------------------
  // Command qualification
  // --------------------------------------------------------------------------
  // With per-device addressing a high DQ0 makes the device ignore the mode-set
  assign in_cal       = (st_r.mode == dq_ref_cal_pkg::CAL_ON);
  assign mode_set_cmd = cmd_valid && (cmd_code == dq_ref_cal_pkg::CMD_MODE_SET);
  assign train_wr     = mode_set_cmd && (cmd_mr_addr == dq_ref_cal_pkg::TRAINING_MR_ADDR)
                        && !(per_device_addressing && pda_dq0_high);
  assign cal_bit      = cmd_data[dq_ref_cal_pkg::CAL_EN_BIT];
  assign range_bit    = cmd_data[dq_ref_cal_pkg::RANGE_BIT];
  assign level_field  = cmd_data[dq_ref_cal_pkg::LEVEL_MSB:0];

  // Commands the far end may issue during calibration
  always_comb begin
    if (per_device_addressing) begin
      allowed_cmd = (cmd_code == dq_ref_cal_pkg::CMD_MODE_SET) ||
                    (cmd_code == dq_ref_cal_pkg::CMD_DESELECT);
    end else begin
      case (cmd_code)
        dq_ref_cal_pkg::CMD_DESELECT,
        dq_ref_cal_pkg::CMD_ACTIVATE,
        dq_ref_cal_pkg::CMD_WRITE,
        dq_ref_cal_pkg::CMD_WRITE_AP,
        dq_ref_cal_pkg::CMD_READ,
        dq_ref_cal_pkg::CMD_READ_AP,
        dq_ref_cal_pkg::CMD_PRECHARGE,
        dq_ref_cal_pkg::CMD_MODE_SET: allowed_cmd = 1'b1;
        default:                      allowed_cmd = 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // Illegal commands are only flagged; a range-change level write still stores its level but keeps the range
  always_comb begin
    st_nxt         = st_r;
    st_nxt.illegal = 1'b0;
    case (st_r.mode)
      dq_ref_cal_pkg::CAL_OFF: begin
        if (train_wr && cal_bit) begin
          st_nxt.mode  = dq_ref_cal_pkg::CAL_ON;
          st_nxt.range = range_bit;
        end
      end
      dq_ref_cal_pkg::CAL_ON: begin
        if (cmd_valid && !allowed_cmd) begin
          st_nxt.illegal = 1'b1;
        end
        if (train_wr && cal_bit) begin
          st_nxt.level = level_field;
          st_nxt.valid = 1'b1;
          if (range_bit != st_r.range) begin
            st_nxt.illegal = 1'b1;
          end
        end else if (train_wr) begin
          st_nxt.mode = dq_ref_cal_pkg::CAL_OFF;
        end
      end
      default: begin
        st_nxt.mode = dq_ref_cal_pkg::CAL_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{mode:    dq_ref_cal_pkg::CAL_OFF,
                range:   dq_ref_cal_pkg::RANGE_RST,
                level:   dq_ref_cal_pkg::LEVEL_RST,
                valid:   1'b0,
                illegal: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Stored pair stays the operating reference after exit
  assign cal_mode    = in_cal;
  assign ref_range   = st_r.range;
  assign ref_level   = st_r.level;
  assign ref_valid   = st_r.valid;
  assign cmd_illegal = st_r.illegal;

  // Supply fraction of the current code, one cycle behind ref_level
  ref_level_decode u_decode (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .range_sel  (st_r.range),
    .level_code (st_r.level),
    .frac_r     (ref_frac),
    .reserved_r (ref_reserved)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // Expected supply fraction, worked from the stored pair by scaling the code
  logic [dq_ref_cal_pkg::FRAC_W-1:0] frac_expect;
  assign frac_expect = (ref_range ? dq_ref_cal_pkg::RANGE2_BASE : dq_ref_cal_pkg::RANGE1_BASE)
                       + (dq_ref_cal_pkg::FRAC_W'(ref_level) * dq_ref_cal_pkg::LEVEL_STEP);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_ENTRY_RANGE: assert property (
    (train_wr && cal_bit && !in_cal) |=> (cal_mode && ref_range == $past(range_bit)))
    else $error("entry did not latch range");
  AST_ENTRY_KEEPS_LEVEL: assert property (
    (train_wr && cal_bit && !in_cal) |=> $stable(ref_level))
    else $error("entry altered level");
  AST_LEVEL_SET: assert property (
    (train_wr && cal_bit && in_cal) |=> (ref_level == $past(level_field) && ref_valid))
    else $error("level write not taken");
  AST_BIT7_LOW_KEEPS: assert property (
    (train_wr && !cal_bit) |=> ($stable(ref_level) && $stable(ref_range)))
    else $error("bit 7 low changed stored bits");
  AST_EXIT_CLEARS: assert property (
    (train_wr && !cal_bit && in_cal) |=> !cal_mode)
    else $error("exit did not clear mode");
  AST_HOLD_AFTER_EXIT: assert property (
    (!cal_mode && !(train_wr && cal_bit)) |=> ($stable(ref_level) && $stable(ref_range)))
    else $error("reference changed outside calibration");
  AST_RANGE_CHANGE: assert property (
    (train_wr && cal_bit && in_cal && range_bit != ref_range)
      |=> (cmd_illegal && $stable(ref_range)))
    else $error("range change not flagged");
  AST_BAD_CMD: assert property (
    (in_cal && cmd_valid && !allowed_cmd) |=> cmd_illegal)
    else $error("disallowed command not flagged");
  AST_QUIET_OUTSIDE: assert property (
    !in_cal |=> !cmd_illegal)
    else $error("offence flagged outside calibration");
  AST_PDA_IGNORED: assert property (
    (mode_set_cmd && per_device_addressing && pda_dq0_high)
      |=> ($stable(ref_level) && $stable(cal_mode)))
    else $error("masked mode-set was executed");
  AST_FRAC_MAP: assert property (
    1'b1 |=> (ref_frac == $past(frac_expect)))
    else $error("fraction mismatch");
  AST_RESERVED_FLAG: assert property (
    1'b1 |=> (ref_reserved == ($past(ref_level) > dq_ref_cal_pkg::LEVEL_MAX)))
    else $error("reserved flag mismatch");

  COV_ENTRY: cover property (train_wr && cal_bit && !in_cal);
  COV_LEVEL_THEN_EXIT: cover property (
    (train_wr && cal_bit && in_cal) ##[1:20] (train_wr && !cal_bit && in_cal));
  COV_ILLEGAL: cover property (cmd_illegal);
  COV_RANGE2: cover property (cal_mode && ref_range);
  COV_PDA_MASKED: cover property (mode_set_cmd && per_device_addressing && pda_dq0_high);

endmodule // dq_reference_calibration_mode

// >>> rtl/dq_ref_cal_pkg.sv
// ----------------------------------------------------------------------------
// Constants shared by the reference calibration control and its level decoder
// ----------------------------------------------------------------------------
package dq_ref_cal_pkg;

  // ----------------------------------------------------------------------------
  // Command encoding on cmd_code
  // ----------------------------------------------------------------------------
  localparam logic [3:0] CMD_DESELECT   = 4'h0;
  localparam logic [3:0] CMD_ACTIVATE   = 4'h1;
  localparam logic [3:0] CMD_WRITE      = 4'h2;
  localparam logic [3:0] CMD_WRITE_AP   = 4'h3;
  localparam logic [3:0] CMD_READ       = 4'h4;
  localparam logic [3:0] CMD_READ_AP    = 4'h5;
  localparam logic [3:0] CMD_PRECHARGE  = 4'h6;
  localparam logic [3:0] CMD_MODE_SET   = 4'h7;
  localparam logic [3:0] CMD_REFRESH    = 4'h8;
  localparam logic [3:0] CMD_OTHER      = 4'hf;

  // ----------------------------------------------------------------------------
  // Training mode register address and field layout
  // ----------------------------------------------------------------------------
  localparam logic [2:0] TRAINING_MR_ADDR = 3'h6;
  localparam int         CAL_EN_BIT       = 7;
  localparam int         RANGE_BIT        = 6;
  localparam int         LEVEL_MSB        = 5;
  localparam int         LEVEL_W          = 6;

  // ----------------------------------------------------------------------------
  // Reset values and level table (hundredths of a percent of the I/O supply)
  // ----------------------------------------------------------------------------
  localparam logic             RANGE_RST      = 1'b0;
  localparam logic [LEVEL_W-1:0] LEVEL_RST    = 6'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX    = 6'h32;
  localparam int               FRAC_W         = 14;
  localparam logic [FRAC_W-1:0] RANGE1_BASE   = 14'h1770;
  localparam logic [FRAC_W-1:0] RANGE2_BASE   = 14'h1194;
  localparam logic [FRAC_W-1:0] LEVEL_STEP    = 14'h0041;
  localparam logic [FRAC_W-1:0] FRAC_RST      = 14'h0000;

  // Calibration mode state
  typedef enum logic [0:0] {
    CAL_OFF,
    CAL_ON
  } cal_state_t;

endpackage

// >>> rtl/ref_level_decode.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Maps range and code onto a supply fraction, registered output
// ----------------------------------------------------------------------------
module ref_level_decode (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 range_sel,
  input  wire logic [dq_ref_cal_pkg::LEVEL_W-1:0]   level_code,
  output logic      [dq_ref_cal_pkg::FRAC_W-1:0]    frac_r,
  output logic                                      reserved_r
);

  typedef struct packed {
    logic [dq_ref_cal_pkg::FRAC_W-1:0] frac;
    logic                              reserved;
  } dec_state_t;

  dec_state_t st_r;
  dec_state_t st_nxt;

  // Linear map; reserved codes still decode but are flagged
  always_comb begin
    logic [dq_ref_cal_pkg::FRAC_W-1:0] base;
    logic [dq_ref_cal_pkg::FRAC_W-1:0] ofs;
    base = range_sel ? dq_ref_cal_pkg::RANGE2_BASE : dq_ref_cal_pkg::RANGE1_BASE;
    ofs  = dq_ref_cal_pkg::FRAC_W'(level_code * dq_ref_cal_pkg::LEVEL_STEP);
    st_nxt          = st_r;
    st_nxt.frac     = base + ofs;
    st_nxt.reserved = (level_code > dq_ref_cal_pkg::LEVEL_MAX);
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{frac: dq_ref_cal_pkg::FRAC_RST, reserved: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign frac_r     = st_r.frac;
  assign reserved_r = st_r.reserved;

endmodule // ref_level_decode

// >>> verification/mem_ctrl_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Controller model driving the command inputs
// ----------------------------------------------------------------------------
module mem_ctrl_model (
  input  wire logic        core_clk,
  output logic             cmd_valid,
  output logic [3:0]       cmd_code,
  output logic [2:0]       cmd_mr_addr,
  output logic [7:0]       cmd_data,
  output logic             per_device_addressing,
  output logic             pda_dq0_high
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = dq_ref_cal_pkg::CMD_DESELECT;
    cmd_mr_addr = 3'h0;
    cmd_data = 8'h00;
    per_device_addressing = 1'b0;
    pda_dq0_high = 1'b0;
  end

  // One command after a falling edge, held over one rising edge
  task automatic issue(input logic [3:0] code, input logic [7:0] data);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_mr_addr = dq_ref_cal_pkg::TRAINING_MR_ADDR;
    cmd_data = data;
    @(negedge core_clk);
    // Released lines flip, so a stale value cannot slip through
    cmd_valid = 1'b0;
    cmd_code = dq_ref_cal_pkg::CMD_DESELECT;
    cmd_mr_addr = ~cmd_mr_addr;
    cmd_data = ~cmd_data;
  endtask

  // Controller waits in cycles; plain defaults, not device figures
  localparam int ENTRY_WAIT  = 4;
  localparam int SETTLE_WAIT = 3;
  localparam int EXIT_WAIT   = 4;

  // Entry delay before any calibration-mode command
  task automatic entry_wait;
    repeat (ENTRY_WAIT) @(negedge core_clk);
  endtask

  // Settle time after a level write, before use or exit
  task automatic settle_wait;
    repeat (SETTLE_WAIT) @(negedge core_clk);
  endtask

  // Only deselects until the exit delay has passed
  task automatic exit_wait;
    repeat (EXIT_WAIT) @(negedge core_clk);
  endtask

  // Per-device addressing level and its qualifier
  task automatic set_pda(input logic on, input logic dq0_high);
    @(negedge core_clk);
    per_device_addressing = on;
    pda_dq0_high = dq0_high;
  endtask
endmodule // mem_ctrl_model

// >>> verification/test_dq_reference_calibration_mode.sv
`timescale 1ns/100ps
module test_dq_reference_calibration_mode;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid, per_device_addressing, pda_dq0_high;
  logic [3:0]  cmd_code;
  logic [2:0]  cmd_mr_addr;
  logic [7:0]  cmd_data;
  logic        cal_mode, ref_range, ref_valid, cmd_illegal, ref_reserved;
  logic [5:0]  ref_level;
  logic [13:0] ref_frac;
  int          fail_count = 0;
  int          checks = 0;

  always #50 core_clk = ~core_clk;

  mem_ctrl_model mem_ctrl_model_i (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_mr_addr(cmd_mr_addr), .cmd_data(cmd_data),
    .per_device_addressing(per_device_addressing), .pda_dq0_high(pda_dq0_high));
  dq_reference_calibration_mode dq_reference_calibration_mode_i (.core_clk(core_clk),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_mr_addr(cmd_mr_addr),
    .cmd_data(cmd_data), .per_device_addressing(per_device_addressing),
    .pda_dq0_high(pda_dq0_high), .cal_mode(cal_mode), .ref_range(ref_range),
    .ref_level(ref_level), .ref_valid(ref_valid), .cmd_illegal(cmd_illegal),
    .ref_frac(ref_frac), .ref_reserved(ref_reserved));

  // ----------------------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_vec(input string name, input logic [13:0] exp, input logic [13:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Issue one command, then compare the state one edge later
  task automatic cmd_chk(input logic [3:0] code, input logic [7:0] data, input logic mode,
                         input logic rng, input logic [5:0] lvl, input logic ill);
    mem_ctrl_model_i.issue(code, data);
    chk_bit("cal_mode", mode, cal_mode);
    chk_bit("ref_range", rng, ref_range);
    chk_vec("ref_level", {8'h00, lvl}, {8'h00, ref_level});
    chk_bit("cmd_illegal", ill, cmd_illegal);
  endtask

  // Decoded fraction lags one more edge
  task automatic frac_chk(input logic [13:0] frac, input logic rsv);
    @(negedge core_clk);
    chk_vec("ref_frac", frac, ref_frac);
    chk_bit("ref_reserved", rsv, ref_reserved);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    chk_bit("cal_mode", 1'b0, cal_mode);
    chk_bit("ref_valid", 1'b0, ref_valid);
    chk_vec("ref_level", 14'h0000, {8'h00, ref_level});
  endtask

  task automatic t_range_high;
    logic [3:0] ok [4] = '{dq_ref_cal_pkg::CMD_ACTIVATE, dq_ref_cal_pkg::CMD_WRITE_AP,
                           dq_ref_cal_pkg::CMD_READ_AP, dq_ref_cal_pkg::CMD_PRECHARGE};
    logic [3:0] sweep [4] = '{dq_ref_cal_pkg::CMD_ACTIVATE, dq_ref_cal_pkg::CMD_WRITE,
                              dq_ref_cal_pkg::CMD_READ, dq_ref_cal_pkg::CMD_PRECHARGE};
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'hbf, 1'b1, 1'b0, 6'h00, 1'b0);
    mem_ctrl_model_i.entry_wait();
    cmd_chk(dq_ref_cal_pkg::CMD_WRITE, 8'h00, 1'b1, 1'b0, 6'h00, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h85, 1'b1, 1'b0, 6'h05, 1'b0);
    chk_bit("ref_valid", 1'b1, ref_valid);
    mem_ctrl_model_i.settle_wait();
    frac_chk(14'h18b5, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'hc7, 1'b1, 1'b0, 6'h07, 1'b1);
    @(negedge core_clk);
    chk_bit("cmd_illegal", 1'b0, cmd_illegal);
    cmd_chk(dq_ref_cal_pkg::CMD_REFRESH, 8'h00, 1'b1, 1'b0, 6'h07, 1'b1);
    foreach (ok[i]) cmd_chk(ok[i], 8'h00, 1'b1, 1'b0, 6'h07, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'hb2, 1'b1, 1'b0, 6'h32, 1'b0);
    frac_chk(14'h2422, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'hb3, 1'b1, 1'b0, 6'h33, 1'b0);
    frac_chk(14'h2463, 1'b1);
    foreach (sweep[i]) cmd_chk(sweep[i], 8'h00, 1'b1, 1'b0, 6'h33, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_PRECHARGE, 8'h00, 1'b1, 1'b0, 6'h33, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h85, 1'b1, 1'b0, 6'h05, 1'b0);
    mem_ctrl_model_i.settle_wait();
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h00, 1'b0, 1'b0, 6'h05, 1'b0);
    mem_ctrl_model_i.exit_wait();
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h45, 1'b0, 1'b0, 6'h05, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_REFRESH, 8'h00, 1'b0, 1'b0, 6'h05, 1'b0);
  endtask

  task automatic t_range_low;
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'hc0, 1'b1, 1'b1, 6'h05, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'hc0, 1'b1, 1'b1, 6'h00, 1'b0);
    frac_chk(14'h1194, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h3f, 1'b0, 1'b1, 6'h00, 1'b0);
  endtask

  task automatic t_pda;
    mem_ctrl_model_i.set_pda(1'b1, 1'b1);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h80, 1'b0, 1'b1, 6'h00, 1'b0);
    mem_ctrl_model_i.set_pda(1'b1, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h80, 1'b1, 1'b0, 6'h00, 1'b0);
    cmd_chk(dq_ref_cal_pkg::CMD_WRITE, 8'h00, 1'b1, 1'b0, 6'h00, 1'b1);
    cmd_chk(dq_ref_cal_pkg::CMD_MODE_SET, 8'h00, 1'b0, 1'b0, 6'h00, 1'b0);
    mem_ctrl_model_i.set_pda(1'b0, 1'b0);
  endtask

  // Main sequence, reset released at a falling edge
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    t_reset();
    rst_n = 1'b1;
    t_range_high();
    t_range_low();
    t_pda();
    stop_test();
  end

  // Watchdog, far beyond the fewer than a hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end
endmodule // test_dq_reference_calibration_mode
